// ### design/adc_trig_map.vh
// Register offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_TRIG_MAP_VH
`define ADC_TRIG_MAP_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define CONVERTER_CONTROL_OFFSET  32'hE003_4000
`define CONVERTER_STATUS_OFFSET   32'hE003_4034
`define ADDR_DECODE_MASK          32'hFFFF_FFFC
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CHAN_SEL_LSB              0
`define CHAN_SEL_MSB              7
`define DIV_LSB                   8
`define DIV_MSB                   15
`define SCAN_BIT                  16
`define RES_LSB                   17
`define RES_MSB                   19
`define POWER_BIT                 21
`define TRIG_LSB                  24
`define TRIG_MSB                  26
`define EDGE_BIT                  27
`define CTRL_WRITABLE_MASK        32'h0F2F_FFFF
`define CTRL_RESET                32'h0000_0001
// ----------------------------------------
// Trigger codes, timing counts, result width and status bit positions
// ----------------------------------------
`define TRIG_NONE                 3'h0
`define TRIG_NOW                  3'h1
`define TRIG_PIN16                3'h2
`define CLOCKS_AT_CODE0           4'hB
`define CLOCKS_AT_MAX             4'h4
`define RES_BITS_AT_CODE0         4'hA
`define STATUS_BUSY_BIT           0
`define STATUS_DONE_BIT           1
`define STATUS_RES_LSB            4
`define STATUS_RES_MSB            7
`endif

// ### design/edge_catcher.v
// Two-stage synchroniser and one-cycle edge detector for one trigger source
`timescale 1ns/1ps
module edge_catcher (
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  input  wire din,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg sync_q;
  reg last_q;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else if (ce) begin
      meta_q <= din;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = ce & sync_q & ~last_q;
  assign fall = ce & ~sync_q & last_q;
endmodule

// ### design/adc_conversion_trigger_control.v
// Converter control register, AHB-Lite slave and conversion start sequencer
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "adc_trig_map.vh"
module adc_conversion_trigger_control #(
  parameter DIV_W = 8
) (
  input  wire        MCLK,
  input  wire        RST_N,
  input  wire        CE,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  input  wire        PORT_PIN_SIXTEEN,
  input  wire        PORT_PIN_TWENTYTWO,
  input  wire        TIMER0_MATCH1,
  input  wire        TIMER0_MATCH3,
  input  wire        TIMER1_MATCH0,
  input  wire        TIMER1_MATCH1,
  output reg         CONVERTER_POWERED,
  output reg         CONV_CLK,
  output reg         CONV_START,
  output reg         CONV_BUSY,
  output reg         CONV_DONE,
  output reg  [3:0]  RESULT_BITS,
  output reg  [7:0]  CHANNEL_SELECT,
  output reg         REPEAT_SCAN
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  reg [31:0]      ctrl_q;
  reg [31:0]      ctrl_d;
  reg             wr_pend_q;
  reg [31:0]      rd_data_d;
  reg [31:0]      status_word;
  reg             now_q;
  reg [1:0]       state_q;
  reg [DIV_W-1:0] div_cnt_q;
  reg [3:0]       clk_cnt_q;
  reg             conv_clk_q;

  wire [2:0]       trig_code = ctrl_q[`TRIG_MSB:`TRIG_LSB];
  wire [2:0]       res_code  = ctrl_q[`RES_MSB:`RES_LSB];
  wire             scan_on   = ctrl_q[`SCAN_BIT];
  wire             powered   = ctrl_q[`POWER_BIT];
  wire             falling   = ctrl_q[`EDGE_BIT];
  wire [DIV_W-1:0] div_val   = ctrl_q[`DIV_LSB +: DIV_W];
  wire [3:0]       conv_len  = `CLOCKS_AT_CODE0 - {1'b0, res_code};

  // ----------------------------------------
  // Trigger sources
  // ----------------------------------------
  wire [5:0] src = {TIMER1_MATCH1, TIMER1_MATCH0, TIMER0_MATCH3, TIMER0_MATCH1,
                    PORT_PIN_TWENTYTWO, PORT_PIN_SIXTEEN};
  wire [5:0] rise;
  wire [5:0] fall;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_src
      edge_catcher u_catch (
        .clk   (MCLK),
        .rst_n (RST_N),
        .ce    (CE),
        .din   (src[gi]),
        .rise  (rise[gi]),
        .fall  (fall[gi])
      );
    end
  endgenerate

  // Codes 010..111 index sources 0..5; polarity only applies there
  wire [2:0] src_idx  = trig_code - `TRIG_PIN16;
  wire       is_edge  = trig_code >= `TRIG_PIN16;
  wire       edge_hit = is_edge & (falling ? fall[src_idx] : rise[src_idx]);
  // A write of code 001 fires once; the request waits until the sequencer is idle
  wire       start_req = powered & ~scan_on & (now_q | edge_hit);
  // Repeated scan only runs with the trigger field cleared; any other code stalls it
  wire       scan_req  = powered & scan_on & (trig_code == `TRIG_NONE);

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  wire take = HSEL & HREADY & HTRANS[1];
  wire hit  = (HADDR & `ADDR_DECODE_MASK) == `CONVERTER_CONTROL_OFFSET;
  wire hit_s = (HADDR & `ADDR_DECODE_MASK) == `CONVERTER_STATUS_OFFSET;

  always @* begin
    ctrl_d = ctrl_q;
    if (wr_pend_q)
      ctrl_d = HWDATA & `CTRL_WRITABLE_MASK;
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // A read right behind a write sees the value being written
  always @* begin
    status_word = 32'h0000_0000;
    status_word[`STATUS_RES_MSB:`STATUS_RES_LSB] = `RES_BITS_AT_CODE0 - {1'b0, res_code};
    status_word[`STATUS_DONE_BIT] = CONV_DONE;
    status_word[`STATUS_BUSY_BIT] = CONV_BUSY;
    if (hit)
      rd_data_d = ctrl_d;
    else if (hit_s)
      rd_data_d = status_word;
    else
      rd_data_d = 32'h0000_0000;
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q    <= `CTRL_RESET;
      wr_pend_q <= 1'b0;
      now_q     <= 1'b0;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else if (CE) begin
      ctrl_q    <= ctrl_d;
      wr_pend_q <= take & HWRITE & hit;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      // Start-now is a one-shot armed by the write, not a level
      if (wr_pend_q && HWDATA[`TRIG_MSB:`TRIG_LSB] == `TRIG_NOW)
        now_q <= 1'b1;
      else if (state_q == ST_IDLE || !powered)
        now_q <= 1'b0;
      if (take && !HWRITE)
        HRDATA <= rd_data_d;
    end
  end

  // ----------------------------------------
  // Converter clock and sequencer
  // ----------------------------------------
  // Dividing by the field plus one; the converter clock only counts while powered
  wire tick = powered & (div_cnt_q == div_val);

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt_q  <= {DIV_W{1'b0}};
      conv_clk_q <= 1'b0;
      state_q    <= ST_IDLE;
      clk_cnt_q  <= 4'h0;
    end else if (CE) begin
      if (!powered || tick)
        div_cnt_q <= {DIV_W{1'b0}};
      else
        div_cnt_q <= div_cnt_q + 1'b1;
      if (tick)
        conv_clk_q <= ~conv_clk_q;
      case (state_q)
        ST_IDLE: begin
          if (start_req || scan_req) begin
            state_q   <= ST_CONV;
            clk_cnt_q <= scan_on ? conv_len : `CLOCKS_AT_CODE0;
          end
        end
        ST_CONV: begin
          // Power-down aborts; edges during a conversion are dropped
          if (!powered)
            state_q <= ST_IDLE;
          else if (tick && conv_clk_q) begin
            if (clk_cnt_q == 4'h1)
              state_q <= ST_IDLE;
            clk_cnt_q <= clk_cnt_q - 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      CONVERTER_POWERED <= 1'b0;
      CONV_CLK          <= 1'b0;
      CONV_START        <= 1'b0;
      CONV_BUSY         <= 1'b0;
      CONV_DONE         <= 1'b0;
      RESULT_BITS       <= `RES_BITS_AT_CODE0;
      CHANNEL_SELECT    <= 8'h01;
      REPEAT_SCAN       <= 1'b0;
    end else if (CE) begin
      CONVERTER_POWERED <= powered;
      CONV_CLK          <= conv_clk_q;
      CONV_START        <= (state_q == ST_IDLE) & (start_req | scan_req);
      CONV_BUSY         <= state_q == ST_CONV;
      CONV_DONE         <= (state_q == ST_CONV) & powered & tick & conv_clk_q & (clk_cnt_q == 4'h1);
      RESULT_BITS       <= `RES_BITS_AT_CODE0 - {1'b0, res_code};
      CHANNEL_SELECT    <= ctrl_q[`CHAN_SEL_MSB:`CHAN_SEL_LSB];
      REPEAT_SCAN       <= scan_on;
    end
  end
endmodule

// ### test/trig_src_model.sv
// Trigger sources: two port pins and four timer match outputs
`timescale 1ns/1ps
module trig_src_model (
  input  wire       clk,
  input  wire       lvl,
  input  wire [2:0] idx,
  input  wire       go,
  output reg  [5:0] src
);
  integer n = 0;
  initial src = 6'h00;
  // Pulse is held about 20 cycles, so a start on the wrong edge comes late
  always @(posedge clk) begin
    n <= go ? 20 : (n > 0 ? n - 1 : 0);
    src <= {6{lvl}} ^ (n > 1 ? 6'h01 << idx : 6'h00);
  end
endmodule

// ### test/adc_trig_chk.sv
// Port checks for the converter control block
`timescale 1ns/1ps
`include "adc_trig_map.vh"
module adc_trig_chk (
  input wire        MCLK,
  input wire        RST_N,
  input wire        HSEL,
  input wire [31:0] HADDR,
  input wire [1:0]  HTRANS,
  input wire        HWRITE,
  input wire        HREADYOUT,
  input wire        HRESP,
  input wire        CONVERTER_POWERED,
  input wire        CONV_START,
  input wire        CONV_BUSY,
  input wire        CONV_DONE,
  input wire [3:0]  RESULT_BITS
);
  reg wr_q;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Control write seen; the power output may only move one or two cycles later
  always @(posedge MCLK or negedge RST_N)
    if (!RST_N) wr_q <= 1'b0;
    else wr_q <= HSEL && HTRANS[1] && HWRITE && HADDR == `CONVERTER_CONTROL_OFFSET;
  property p_pwr; $changed(CONVERTER_POWERED) |-> $past(wr_q) || $past(wr_q, 2); endproperty
  a_pwr: assert property (p_pwr) else $error("power moved without write");
  property p_off; $fell(CONVERTER_POWERED) |-> ##[0:2] !CONV_BUSY; endproperty
  a_off: assert property (p_off) else $error("busy after power-down");
  property p_spwr; CONV_START |-> CONVERTER_POWERED; endproperty
  a_spwr: assert property (p_spwr) else $error("start while powered down");
  property p_gap; CONV_START |=> !CONV_START [*6]; endproperty
  a_gap: assert property (p_gap) else $error("start during conversion");
  property p_len; CONV_START |=> (CONV_BUSY || !CONVERTER_POWERED) [*6]; endproperty
  a_len: assert property (p_len) else $error("conversion too short");
  property p_res; CONV_START |-> RESULT_BITS >= 4'h3 && RESULT_BITS <= 4'hA; endproperty
  a_res: assert property (p_res) else $error("result width out of range");
  property p_done; CONV_DONE |-> CONV_BUSY ##1 !CONV_BUSY; endproperty
  a_done: assert property (p_done) else $error("busy not cleared after done");
  property p_dst; CONV_DONE |-> !CONV_START; endproperty
  a_dst: assert property (p_dst) else $error("start with done");
  property p_rbits; $changed(RESULT_BITS) |-> $past(wr_q) || $past(wr_q, 2); endproperty
  a_rbits: assert property (p_rbits) else $error("result width moved without write");
  property p_okay; HREADYOUT && !HRESP; endproperty
  a_okay: assert property (p_okay) else $error("bus stalled or error response");
endmodule
bind adc_conversion_trigger_control adc_trig_chk i_adc_trig_chk (.MCLK, .RST_N, .HSEL, .HADDR, .HTRANS,
  .HWRITE, .HREADYOUT, .HRESP, .CONVERTER_POWERED, .CONV_START, .CONV_BUSY, .CONV_DONE, .RESULT_BITS);

// ### test/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_trig_map.vh"
module tb_top;
  localparam logic [31:0] CTRL = `CONVERTER_CONTROL_OFFSET;
  logic        MCLK, RST_N, CE, HSEL, HWRITE, lvl, go, rph;
  logic [31:0] HADDR, HWDATA, base, v;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE, idx;
  wire  [5:0]  src;
  wire  [31:0] HRDATA;
  wire  [3:0]  RESULT_BITS;
  wire         HREADYOUT, CONV_START, CONV_DONE, CONVERTER_POWERED, CONV_CLK, REPEAT_SCAN;
  wire  [7:0]  CHANNEL_SELECT;
  logic        ck = 1'b0;
  int          tk = -1;
  logic [31:0] rd_q[$];
  int          st_q[$], dn_q[$], fail_count, comparisons, seed, cyc, t0, tol, dv, rs, c, p;
  adc_conversion_trigger_control i_adc_conversion_trigger_control (.MCLK, .RST_N, .CE, .HSEL, .HADDR,
    .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP(),
    .PORT_PIN_SIXTEEN(src[0]), .PORT_PIN_TWENTYTWO(src[1]), .TIMER0_MATCH1(src[2]), .TIMER0_MATCH3(src[3]),
    .TIMER1_MATCH0(src[4]), .TIMER1_MATCH1(src[5]), .CONVERTER_POWERED, .CONV_CLK, .CONV_START,
    .CONV_BUSY(), .CONV_DONE, .RESULT_BITS, .CHANNEL_SELECT, .REPEAT_SCAN);
  trig_src_model i_trig_src_model (.clk(MCLK), .lvl, .idx, .go, .src);
  // ----
  // Checking and bus tasks
  // ----
  task automatic miss(input string m);
    fail_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d, fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp_rd(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) miss("read data");
  endtask
  task automatic cmp_res(input logic [3:0] g, e);
    comparisons++;
    if (g !== e) miss("result bits");
  endtask
  task automatic cmp_len(input int g, e);
    comparisons++;
    if (g < e - tol || g > e + tol) miss("conversion length");
  endtask
  task automatic cmp_clk(input int g, e);
    comparisons++;
    if (g != e) miss("converter clock half period");
  endtask
  task automatic cmp_lvl(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) miss("control level output");
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  // Waits for pending starts (and dones when all is set) under a bound
  task automatic settle(input int n, input bit all);
    int k;
    for (k = 0; k < n && (st_q.size() > 0 || all && dn_q.size() > 0); k++) @(posedge MCLK);
    if (k == n) begin
      miss("timeout");
      print_verdict;
    end
  endtask
  task automatic step;
    int k;
    for (k = 0; k == 0 || HREADYOUT !== 1'b1; k++) begin
      if (k == 20) begin
        miss("bus timeout");
        print_verdict;
      end
      @(posedge MCLK);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR <= a;
    step;
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    rph <= !w;
    step;
    rph <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, e);
    rd_q.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic note(input int n);
    st_q.push_back(10 - rs);
    dn_q.push_back(n * 2 * (dv + 1));
  endtask
  task automatic pulse(input int i);
    idx <= i[2:0];
    go <= 1'b1;
    @(posedge MCLK);
    go <= 1'b0;
  endtask
  always @(posedge MCLK) begin
    cyc++;
    if (rph === 1'b1) cmp_rd(HRDATA, rd_q.pop_front());
    if (CONV_START === 1'b1) begin
      t0 = cyc;
      if (st_q.size() == 0) begin
        comparisons++;
        miss("unexpected start");
      end else cmp_res(RESULT_BITS, 4'(st_q.pop_front()));
    end
    if (CONV_DONE === 1'b1) begin
      if (dn_q.size() == 0) begin
        comparisons++;
        miss("unexpected done");
      end else cmp_len(cyc - t0, dn_q.pop_front());
    end
    // The first toggle after power-up has no reference point
    if (CONV_CLK !== ck) begin
      if (tk >= 0) cmp_clk(cyc - tk, dv + 1);
      tk = cyc;
      ck = CONV_CLK;
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  initial begin
    {RST_N, HSEL, HWRITE, lvl, go, rph, HADDR, HWDATA, HTRANS, idx} = '0;
    CE = 1'b1;
    HSIZE = 3'h2;
    seed = 48;
    wt(10);
    RST_N <= 1'b1;
    rd(CTRL, 32'h0000_0001);
    rd(CTRL + 32'h0000_0008, 32'h0000_0000);
    v = $random(seed) & 32'h000E_FFFF;
    xfer(1'b1, CTRL, v);
    rd(CTRL, v);
    cmp_lvl(CHANNEL_SELECT, v[7:0]);
    dv = $random(seed) & 3;
    rs = $random(seed) & 7;
    tol = 2 * dv + 4;
    base = 32'h0020_0001 | rs << 17 | dv << 8;
    xfer(1'b1, CTRL, base);
    wt(40);
    note(11);
    xfer(1'b1, CTRL, base | 32'h0900_0000);
    settle(8, 0);
    settle(300, 1);
    for (c = 2; c < 8; c++) begin
      for (p = 0; p < 2; p++) begin
        xfer(1'b1, CTRL, base);
        lvl <= p[0];
        wt(6);
        xfer(1'b1, CTRL, base | c << 24 | p << 27);
        pulse((c - 1) % 6);
        wt(30);
        note(11);
        pulse(c - 2);
        settle(8, 0);
        settle(300, 1);
      end
    end
    xfer(1'b1, CTRL, base | 32'h0101_0000);
    wt(60);
    cmp_lvl({7'h00, REPEAT_SCAN}, 8'h01);
    note(11 - rs);
    note(11 - rs);
    xfer(1'b1, CTRL, base | 32'h0001_0000);
    settle(300, 0);
    xfer(1'b1, CTRL, base);
    settle(300, 1);
    cmp_lvl({7'h00, REPEAT_SCAN}, 8'h00);
    // A conversion cut short by power-down must never report done
    st_q.push_back(10 - rs);
    xfer(1'b1, CTRL, base | 32'h0100_0000);
    settle(8, 0);
    xfer(1'b1, CTRL, 32'h0000_0001);
    rd(CTRL, 32'h0000_0001);
    wt(100);
    print_verdict;
  end
endmodule
